// ==== include/sdram_ctl_pkg.sv ====
// shared constants and types for the sdram command and bank state block
package sdram_ctl_pkg;
    // command pins {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam int CLK_MHZ = 125;
    // times in ns
    localparam int ROW_TO_COLUMN_DELAY_NS = 20;
    localparam int ROW_PRECHARGE_TIME_NS = 20;
    localparam int ROW_CYCLE_TIME_NS = 66;
    localparam int MODE_LOAD_DELAY_NS = 16;
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int SELF_REFRESH_EXIT_DELAY_NS = 75;
    // least times round up, at least one cycle
    function automatic int cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RCD_CYC = cyc(ROW_TO_COLUMN_DELAY_NS);
    localparam int RP_CYC = cyc(ROW_PRECHARGE_TIME_NS);
    localparam int RC_CYC = cyc(ROW_CYCLE_TIME_NS);
    localparam int MRD_CYC = cyc(MODE_LOAD_DELAY_NS);
    localparam int WR_CYC = cyc(WRITE_RECOVERY_TIME_NS);
    localparam int XSR_CYC = cyc(SELF_REFRESH_EXIT_DELAY_NS);
    localparam int CNT_W = 8;
    localparam int DEF_CAS_LATENCY = 3;
    localparam int DEF_BURST_LEN = 4;
    // bank states, gray along idle-activating-active-read-write
    typedef enum logic [2:0] {
        BK_IDLE = 3'h0,
        BK_ACTIVATING = 3'h1,
        BK_ACTIVE = 3'h3,
        BK_READ = 3'h2,
        BK_WRITE = 3'h6,
        BK_READ_AP = 3'h7,
        BK_WRITE_AP = 3'h5,
        BK_PRECHARGING = 3'h4
    } bank_st_t;
    // device-wide power state
    typedef enum logic [2:0] {
        PW_NORMAL = 3'h0,
        PW_POWER_DOWN = 3'h1,
        PW_SELF_REFRESH = 3'h3,
        PW_SR_EXIT = 3'h2,
        PW_SUSPEND = 3'h6,
        PW_REFRESHING = 3'h7,
        PW_MODE_LOAD = 3'h5
    } pwr_st_t;
endpackage

// ==== src/sdram_cmd_state.sv ====
// command decode, per-bank state and clock-enable control of an sdram
// Summary of operation
// RULE_01: read to other bank stops auto-precharge write burst; data after cas latency.
// RULE_02: interrupted auto-precharge write bank precharges after write recovery from read.
// RULE_03: last word written is the one one clock before the interrupting read.
// RULE_04: write to other bank: interrupted bank precharges after write recovery.
// RULE_05: last word stored is the one one clock before the new write.
// RULE_06: enable action uses current and previous level; low-low keeps state.
// RULE_07: power-down entered high-to-low with nop, all idle; left low-to-high.
// RULE_08: after power-down exit, all banks idle for the next edge.
// RULE_09: controller gives only nop during self-refresh exit delay.
// RULE_10: after clock suspend exit, next command recognised at following edge.
// RULE_11: refresh with enable falling enters self refresh; falling in burst suspends.
// RULE_12: cs high inhibit, LHHH nop, LLHH activates an idle bank.
// RULE_13: LHLH read, LHLL write, in active or burst states, new burst; code starts none from BK_READ_AP or BK_WRITE_AP.
// RULE_14: LLHL precharge; cuts a non-auto-precharge burst and precharges.
// RULE_15: LHHL burst terminate acts on the most recent burst, any bank.
// RULE_16: controller issues refresh and mode load only with all banks idle.
// RULE_17: precharge to an idle bank leaves it unchanged.
// RULE_18: controller precharges all only from states that permit it.
// RULE_19: controller issues nothing to a bank that is in a timed state.
// RULE_20: activating becomes active after rcd; precharging idle after rp.
// RULE_21: auto-precharge bank stays until precharge time met, then idle.
// RULE_22: controller gives only nop during refresh, mode load, precharge all.
`timescale 1ns/1ps
module sdram_cmd_state #(
    parameter int BANKS = 4,
    parameter int CAS_LATENCY = sdram_ctl_pkg::DEF_CAS_LATENCY,
    parameter int BURST_LEN = sdram_ctl_pkg::DEF_BURST_LEN
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // command pins, already sampled
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic [1:0] BA_I,
    input wire logic A10_I,
    // state outputs
    output logic [3*BANKS-1:0] BANK_STATE_O,
    output logic [2:0] PWR_STATE_O,
    output logic ALL_IDLE_O,
    // data path strobes
    output logic WR_STROBE_O,
    output logic [1:0] WR_BANK_O,
    output logic RD_VALID_O,
    output logic [1:0] RD_BANK_O,
    output logic [BANKS-1:0] PRECHARGE_START_O
);
    localparam int CW = sdram_ctl_pkg::CNT_W;
    localparam logic [CW-1:0] RCD_N = CW'(sdram_ctl_pkg::RCD_CYC);
    localparam logic [CW-1:0] RP_N = CW'(sdram_ctl_pkg::RP_CYC);
    localparam logic [CW-1:0] RC_N = CW'(sdram_ctl_pkg::RC_CYC);
    localparam logic [CW-1:0] MRD_N = CW'(sdram_ctl_pkg::MRD_CYC);
    localparam logic [CW-1:0] WR_N = CW'(sdram_ctl_pkg::WR_CYC);
    localparam logic [CW-1:0] XSR_N = CW'(sdram_ctl_pkg::XSR_CYC);
    localparam logic [CW-1:0] BL_N = CW'(BURST_LEN);
    localparam logic [CW-1:0] ONE = CW'(1);
    localparam logic [CW-1:0] ZERO = '0;
    logic cke_prev_r;
    sdram_ctl_pkg::pwr_st_t pwr_r, pwr_nxt;
    logic [CW-1:0] pwr_cnt_r, pwr_cnt_nxt;
    logic [1:0] last_bank_r;
    logic last_valid_r;
    logic [CAS_LATENCY-1:0] rd_pipe_r;
    logic [2*CAS_LATENCY-1:0] rd_bank_pipe_r;
    sdram_ctl_pkg::bank_st_t bst_r [BANKS];
    logic [CW-1:0] bcnt_r [BANKS];
    logic [CW-1:0] burst_r [BANKS];
    logic [BANKS-1:0] pre_start_r;
    // command decode [RULE_12] [RULE_13] [RULE_14] [RULE_15]
    wire [3:0] cmd = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
    wire inhibit = CS_N_I;
    wire is_nop = inhibit || cmd == sdram_ctl_pkg::CMD_NOP;
    wire is_act = !inhibit && cmd == sdram_ctl_pkg::CMD_ACT;
    wire is_rd = !inhibit && cmd == sdram_ctl_pkg::CMD_RD;
    wire is_wr = !inhibit && cmd == sdram_ctl_pkg::CMD_WR;
    wire is_pre = !inhibit && cmd == sdram_ctl_pkg::CMD_PRE;
    wire is_bst = !inhibit && cmd == sdram_ctl_pkg::CMD_BST;
    wire is_ref = !inhibit && cmd == sdram_ctl_pkg::CMD_REF;
    wire is_mrs = !inhibit && cmd == sdram_ctl_pkg::CMD_MRS;
    wire is_col = is_rd || is_wr;
    // enable edges from previous and current level [RULE_06]
    wire cke_fall = cke_prev_r && !CKE_I;
    wire cke_rise = !cke_prev_r && CKE_I;
    wire cke_hold_low = !cke_prev_r && !CKE_I;
    logic [BANKS-1:0] idle_v, burst_v;
    wire all_idle = &idle_v;
    wire any_burst = |burst_v;
    // commands are only executed when internal clock runs normally
    wire run = pwr_r == sdram_ctl_pkg::PW_NORMAL && CKE_I && cke_prev_r;
    // power state decision
    always_comb begin
        pwr_nxt = pwr_r;
        pwr_cnt_nxt = (pwr_cnt_r != ZERO) ? pwr_cnt_r - ONE : ZERO;
        unique case (pwr_r)
            sdram_ctl_pkg::PW_NORMAL: begin
                if (cke_fall && is_ref && all_idle) begin
                    pwr_nxt = sdram_ctl_pkg::PW_SELF_REFRESH; // [RULE_11]
                end else if (cke_fall && is_nop && all_idle) begin
                    pwr_nxt = sdram_ctl_pkg::PW_POWER_DOWN; // [RULE_07]
                end else if (cke_fall && any_burst) begin
                    pwr_nxt = sdram_ctl_pkg::PW_SUSPEND; // [RULE_11]
                end else if (run && is_ref && all_idle) begin
                    pwr_nxt = sdram_ctl_pkg::PW_REFRESHING;
                    pwr_cnt_nxt = RC_N - ONE;
                end else if (run && is_mrs && all_idle) begin
                    pwr_nxt = sdram_ctl_pkg::PW_MODE_LOAD;
                    pwr_cnt_nxt = MRD_N - ONE;
                end
            end
            sdram_ctl_pkg::PW_POWER_DOWN: begin
                // exit leaves banks idle for the very next edge
                if (cke_rise && is_nop) begin
                    pwr_nxt = sdram_ctl_pkg::PW_NORMAL; // [RULE_07] [RULE_08]
                end
            end
            sdram_ctl_pkg::PW_SELF_REFRESH: begin
                if (cke_rise && is_nop) begin
                    pwr_nxt = sdram_ctl_pkg::PW_SR_EXIT;
                    pwr_cnt_nxt = XSR_N - ONE;
                end
            end
            sdram_ctl_pkg::PW_SR_EXIT: begin
                // controller keeps nop here [RULE_09]
                if (pwr_cnt_r == ZERO) begin
                    pwr_nxt = sdram_ctl_pkg::PW_NORMAL;
                end
            end
            sdram_ctl_pkg::PW_SUSPEND: begin
                if (cke_rise) begin
                    pwr_nxt = sdram_ctl_pkg::PW_NORMAL; // [RULE_10]
                end
            end
            sdram_ctl_pkg::PW_REFRESHING,
            sdram_ctl_pkg::PW_MODE_LOAD: begin
                // only nop accepted here [RULE_22]
                if (pwr_cnt_r == ZERO) begin
                    pwr_nxt = sdram_ctl_pkg::PW_NORMAL;
                end
            end
            default: pwr_nxt = sdram_ctl_pkg::PW_NORMAL;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pwr_r <= sdram_ctl_pkg::PW_NORMAL;
            pwr_cnt_r <= ZERO;
            cke_prev_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            pwr_cnt_r <= pwr_cnt_nxt;
            cke_prev_r <= CKE_I;
        end
    end

    // most recent burst owner for burst terminate [RULE_15]
    wire col_go = run && is_col;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            last_bank_r <= 2'h0;
            last_valid_r <= 1'b0;
        end else if (col_go) begin
            last_bank_r <= BA_I;
            last_valid_r <= 1'b1;
        end
    end

    // per-bank state machines
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            wire sel = BA_I == 2'(b);
            wire go = run;
            wire in_rd = bst_r[b] == sdram_ctl_pkg::BK_READ ||
                bst_r[b] == sdram_ctl_pkg::BK_READ_AP;
            wire in_wr = bst_r[b] == sdram_ctl_pkg::BK_WRITE ||
                bst_r[b] == sdram_ctl_pkg::BK_WRITE_AP;
            wire bursting = (in_rd || in_wr) && burst_r[b] > ONE;
            wire col_ok = bst_r[b] == sdram_ctl_pkg::BK_ACTIVE ||
                bst_r[b] == sdram_ctl_pkg::BK_READ ||
                bst_r[b] == sdram_ctl_pkg::BK_WRITE;
            // another bank's column command interrupts this burst
            wire other_col = go && is_col && !sel && bursting;
            wire ap_wr_cut = other_col &&
                bst_r[b] == sdram_ctl_pkg::BK_WRITE_AP;
            wire ap_rd_cut = other_col &&
                bst_r[b] == sdram_ctl_pkg::BK_READ_AP;
            wire pre_hit = go && is_pre && (sel || A10_I);
            wire bst_hit = go && is_bst && last_valid_r &&
                last_bank_r == 2'(b) && bursting;
            // auto-precharge burst done on its own: write waits recovery
            wire ap_end = (bst_r[b] == sdram_ctl_pkg::BK_READ_AP ||
                bst_r[b] == sdram_ctl_pkg::BK_WRITE_AP) &&
                burst_r[b] == ONE && !other_col && CKE_I;
            assign idle_v[b] = bst_r[b] == sdram_ctl_pkg::BK_IDLE;
            assign burst_v[b] = bursting;
            always_ff @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    bst_r[b] <= sdram_ctl_pkg::BK_IDLE;
                    bcnt_r[b] <= ZERO;
                    burst_r[b] <= ZERO;
                    pre_start_r[b] <= 1'b0;
                end else begin
                    pre_start_r[b] <= 1'b0;
                    if (bcnt_r[b] != ZERO) begin
                        bcnt_r[b] <= bcnt_r[b] - ONE;
                    end
                    // burst counter frozen while suspended
                    if (burst_r[b] != ZERO && CKE_I &&
                        pwr_r == sdram_ctl_pkg::PW_NORMAL) begin
                        burst_r[b] <= burst_r[b] - ONE;
                    end
                    if (go && is_act && sel &&
                        bst_r[b] == sdram_ctl_pkg::BK_IDLE) begin
                        bst_r[b] <= sdram_ctl_pkg::BK_ACTIVATING; // [RULE_12]
                        bcnt_r[b] <= RCD_N - ONE;
                    end else if (go && is_col && sel && col_ok) begin
                        burst_r[b] <= BL_N; // [RULE_13]
                        bst_r[b] <= is_rd ?
                            (A10_I ? sdram_ctl_pkg::BK_READ_AP :
                                     sdram_ctl_pkg::BK_READ) :
                            (A10_I ? sdram_ctl_pkg::BK_WRITE_AP :
                                     sdram_ctl_pkg::BK_WRITE);
                    end else if (pre_hit && (col_ok ||
                        bst_r[b] == sdram_ctl_pkg::BK_PRECHARGING)) begin
                        // idle bank untouched [RULE_17]
                        bst_r[b] <= sdram_ctl_pkg::BK_PRECHARGING; // [RULE_14]
                        bcnt_r[b] <= RP_N - ONE; // [RULE_20]
                        burst_r[b] <= ZERO;
                        pre_start_r[b] <= 1'b1;
                    end else if (ap_wr_cut) begin
                        // stop data now, precharge after recovery
                        burst_r[b] <= ZERO; // [RULE_01] [RULE_03] [RULE_05]
                        bcnt_r[b] <= WR_N + RP_N - ONE; // [RULE_02] [RULE_04]
                    end else if (ap_rd_cut) begin
                        burst_r[b] <= ZERO;
                        bcnt_r[b] <= RP_N - ONE;
                        pre_start_r[b] <= 1'b1;
                    end else if (other_col || bst_hit) begin
                        burst_r[b] <= ZERO; // [RULE_15]
                        bst_r[b] <= sdram_ctl_pkg::BK_ACTIVE;
                    end else if (ap_end) begin
                        burst_r[b] <= ZERO;
                        bcnt_r[b] <= in_wr ? WR_N + RP_N - ONE : RP_N - ONE;
                        pre_start_r[b] <= !in_wr;
                    end else if (bcnt_r[b] == ZERO) begin
                        unique case (bst_r[b])
                            sdram_ctl_pkg::BK_ACTIVATING:
                                bst_r[b] <= sdram_ctl_pkg::BK_ACTIVE; // [RULE_20]
                            sdram_ctl_pkg::BK_PRECHARGING:
                                bst_r[b] <= sdram_ctl_pkg::BK_IDLE;
                            sdram_ctl_pkg::BK_READ,
                            sdram_ctl_pkg::BK_WRITE: begin
                                if (burst_r[b] == ONE) begin
                                    bst_r[b] <= sdram_ctl_pkg::BK_ACTIVE;
                                end
                            end
                            sdram_ctl_pkg::BK_READ_AP,
                            sdram_ctl_pkg::BK_WRITE_AP: begin
                                if (burst_r[b] == ZERO) begin
                                    bst_r[b] <= sdram_ctl_pkg::BK_IDLE; // [RULE_21]
                                end
                            end
                            default: ;
                        endcase
                    end else if (bcnt_r[b] == RP_N && in_wr &&
                        burst_r[b] == ZERO) begin
                        pre_start_r[b] <= 1'b1; // [RULE_02]
                    end
                end
            end
        end
    endgenerate

    // data strobes: write accepted while a write burst runs, read delayed
    wire [1:0] ab = col_go ? BA_I : last_bank_r;
    wire wr_now = run && ((col_go && is_wr) ||
        (!is_col && !is_bst && !is_pre && last_valid_r &&
         burst_v[last_bank_r] && (bst_r[last_bank_r] ==
         sdram_ctl_pkg::BK_WRITE || bst_r[last_bank_r] ==
         sdram_ctl_pkg::BK_WRITE_AP)));
    wire rd_now = run && ((col_go && is_rd) ||
        (!is_col && !is_bst && !is_pre && last_valid_r &&
         burst_v[last_bank_r] && (bst_r[last_bank_r] ==
         sdram_ctl_pkg::BK_READ || bst_r[last_bank_r] ==
         sdram_ctl_pkg::BK_READ_AP)));

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_pipe_r <= '0;
            rd_bank_pipe_r <= '0;
            WR_STROBE_O <= 1'b0;
            WR_BANK_O <= 2'h0;
        end else begin
            // read data follows cas latency [RULE_01]
            rd_pipe_r <= {rd_pipe_r[CAS_LATENCY-2:0], rd_now};
            rd_bank_pipe_r <= {rd_bank_pipe_r[2*CAS_LATENCY-3:0], ab};
            WR_STROBE_O <= wr_now; // [RULE_03] [RULE_05]
            WR_BANK_O <= ab;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RD_VALID_O <= 1'b0;
            RD_BANK_O <= 2'h0;
            PWR_STATE_O <= 3'h0;
            ALL_IDLE_O <= 1'b1;
        end else begin
            RD_VALID_O <= rd_pipe_r[CAS_LATENCY-2];
            RD_BANK_O <= rd_bank_pipe_r[2*CAS_LATENCY-3:2*CAS_LATENCY-4];
            PWR_STATE_O <= pwr_nxt;
            ALL_IDLE_O <= all_idle;
        end
    end

    generate
        for (b = 0; b < BANKS; b++) begin : g_out
            assign BANK_STATE_O[3*b +: 3] = bst_r[b];
        end
    endgenerate
    assign PRECHARGE_START_O = pre_start_r;

    // checks
    hold_low_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        cke_hold_low && pwr_r != sdram_ctl_pkg::PW_NORMAL |=>
        $stable(pwr_r) || pwr_r == sdram_ctl_pkg::PW_SR_EXIT)
        else $error("power state left with enable held low"); // [RULE_06]
    pd_entry_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        pwr_r == sdram_ctl_pkg::PW_NORMAL && cke_fall && is_nop &&
        all_idle |=> pwr_r == sdram_ctl_pkg::PW_POWER_DOWN)
        else $error("power-down not entered"); // [RULE_07]
    pd_exit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        pwr_r == sdram_ctl_pkg::PW_POWER_DOWN && cke_rise && is_nop
        |=> pwr_r == sdram_ctl_pkg::PW_NORMAL && all_idle)
        else $error("power-down exit late"); // [RULE_08]
    susp_exit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        pwr_r == sdram_ctl_pkg::PW_SUSPEND && cke_rise
        |=> pwr_r == sdram_ctl_pkg::PW_NORMAL)
        else $error("clock suspend exit late"); // [RULE_10]
    act_rcd_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        run && is_act && BA_I == 2'h0 && idle_v[0] |=>
        bst_r[0] == sdram_ctl_pkg::BK_ACTIVATING [*3] ##1
        bst_r[0] == sdram_ctl_pkg::BK_ACTIVE)
        else $error("activation timing wrong"); // [RULE_20]
    pre_idle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        run && is_pre && !A10_I && idle_v[BA_I] |=>
        idle_v[$past(BA_I)])
        else $error("precharge changed idle bank"); // [RULE_17]
    wr_cut_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        run && is_rd && BA_I != 2'h0 && burst_v[0] &&
        bst_r[0] == sdram_ctl_pkg::BK_WRITE_AP |=>
        !burst_v[0] ##[1:6] PRECHARGE_START_O[0])
        else $error("interrupted write precharge wrong"); // [RULE_02]
    rd_lat_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        rd_now |-> ##CAS_LATENCY RD_VALID_O)
        else $error("read data not at cas latency"); // [RULE_01]
    sr_entry_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        pwr_r == sdram_ctl_pkg::PW_SELF_REFRESH);
    susp_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        pwr_r == sdram_ctl_pkg::PW_SUSPEND);
    ap_cut_c: cover property (@(posedge CLK_I) disable iff (RST_I)
        run && is_wr && burst_v[0] && !BA_I[0] == 1'b0);
endmodule

// ==== verif/sdram_host_model.sv ====
// controller model that drives the sdram command pins
`timescale 1ns/1ps
module sdram_host_model (
    // clock
    input wire logic clk_i,
    // command pins, cmd_o is {cs_n, ras_n, cas_n, we_n}
    output logic cke_o,
    output logic [3:0] cmd_o,
    output logic [1:0] ba_o,
    output logic a10_o
);
    initial begin
        cke_o = 1'b1;
        cmd_o = sdram_ctl_pkg::CMD_NOP;
        ba_o = 2'h0;
        a10_o = 1'b0;
    end
    // one command held for exactly one edge
    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                       input logic a, input logic k);
        @(posedge clk_i);
        #1;
        cmd_o = c;
        ba_o = b;
        a10_o = a;
        cke_o = k;
    endtask
    // first two are true nops so a self-refresh exit always sees them;
    // address lines flip so stale values never look valid
    task automatic no_operation_command(input int n, input logic k);
        for (int i = 0; i < n; i++)
            cmd((i < 2 || $urandom % 2) ? sdram_ctl_pkg::CMD_NOP
                : {1'b1, 3'($urandom)}, ~ba_o, ~a10_o, k);
    endtask
endmodule

// ==== verif/sdram_cmd_state_tb_top.sv ====
// self-checking bench for the sdram command and bank state block
`timescale 1ns/1ps
module sdram_cmd_state_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke, a10, all_idle, wr_stb, rd_vld;
    logic [3:0] cmd, pre_go;
    logic [1:0] ba, wr_bank, rd_bank, rd_b;
    logic [11:0] bank_st;
    logic [2:0] pwr;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int rd_cyc;
    int pc_cyc[4];
    int wcnt[4];
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    sdram_host_model host (
        .clk_i(clk), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .a10_o(a10));
    sdram_cmd_state sdram_cmd_state_inst (
        .CLK_I(clk), .RST_I(rst), .CKE_I(cke), .CS_N_I(cmd[3]),
        .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .BA_I(ba),
        .A10_I(a10), .BANK_STATE_O(bank_st), .PWR_STATE_O(pwr),
        .ALL_IDLE_O(all_idle), .WR_STROBE_O(wr_stb), .WR_BANK_O(wr_bank),
        .RD_VALID_O(rd_vld), .RD_BANK_O(rd_bank),
        .PRECHARGE_START_O(pre_go));
    // event log, read once the edge's updates have landed
    always @(posedge clk) begin
        #1;
        if (rd_vld === 1'b1 && rd_cyc < 0) begin
            rd_cyc = cyc + 1; // controller takes it at the next edge
            rd_b = rd_bank;
        end
        for (int b = 0; b < 4; b++) begin
            if (pre_go[b] === 1'b1) pc_cyc[b] = cyc;
            if (wr_stb === 1'b1 && wr_bank == 2'(b)) wcnt[b]++;
        end
    end
    function automatic logic [2:0] st(input int b);
        return bank_st[3*b +: 3];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        int m, n, g, i;
        logic [3:0] op;
        void'($urandom(93338));
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        host.no_operation_command(2, 1'b1);
        chk({all_idle, pwr, bank_st}, 16'h8000);
        host.cmd(sdram_ctl_pkg::CMD_PRE, 2'($urandom), 1'b0, 1'b1);
        host.no_operation_command(2, 1'b1);
        chk(bank_st, 16'h0);
        // write with auto precharge cut by a read or write elsewhere
        for (int k = 0; k < 4; k++) begin
            n = $urandom % 4;
            m = (n + 1 + $urandom % 3) % 4;
            g = 1 + $urandom % 3;
            op = k[0] ? sdram_ctl_pkg::CMD_WR : sdram_ctl_pkg::CMD_RD;
            host.cmd(sdram_ctl_pkg::CMD_ACT, 2'(n), 1'b0, 1'b1);
            host.cmd(sdram_ctl_pkg::CMD_ACT, 2'(m), 1'b0, 1'b1);
            host.no_operation_command(1, 1'b1);
            chk({st(n), st(m)}, 16'h9);
            host.no_operation_command(sdram_ctl_pkg::RCD_CYC, 1'b1);
            chk({st(n), st(m)}, 16'h1b);
            wcnt[n] = 0;
            wcnt[m] = 0;
            pc_cyc[n] = -1;
            rd_cyc = -1;
            host.cmd(sdram_ctl_pkg::CMD_WR, 2'(n), 1'b1, 1'b1);
            host.no_operation_command(g - 1, 1'b1);
            host.cmd(op, 2'(m), 1'b0, 1'b1);
            i = cyc + 1;
            chk(st(n), 16'h5);
            host.no_operation_command(12, 1'b1);
            chk(16'(wcnt[n]), 16'(g));
            chk(16'(pc_cyc[n] - i), 16'(sdram_ctl_pkg::WR_CYC));
            chk(st(n), 16'h0);
            if (k[0]) begin
                chk(16'(wcnt[m]),
                    16'(sdram_ctl_pkg::DEF_BURST_LEN));
            end
            if (!k[0]) begin
                chk(16'(rd_cyc - i), 16'(sdram_ctl_pkg::DEF_CAS_LATENCY));
                chk(rd_b, 16'(m));
            end
            // bank m is active and all other banks are idle, so precharge-all is legal
            host.cmd(sdram_ctl_pkg::CMD_PRE, 2'($urandom), 1'b1, 1'b1);
            host.no_operation_command(sdram_ctl_pkg::RP_CYC + 2, 1'b1);
            chk({all_idle, bank_st}, 16'h1000);
        end
        // burst terminate, clock suspend, precharge cutting a burst
        host.cmd(sdram_ctl_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
        host.no_operation_command(sdram_ctl_pkg::RCD_CYC, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_RD, 2'h0, 1'b0, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_BST, 2'h3, 1'b0, 1'b1);
        host.no_operation_command(1, 1'b1);
        chk(st(0), 16'h3);
        host.cmd(sdram_ctl_pkg::CMD_RD, 2'h0, 1'b0, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
        host.no_operation_command(3, 1'b0);
        chk(pwr, 16'h6);
        host.cmd(sdram_ctl_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_ACT, 2'h1, 1'b0, 1'b1);
        host.no_operation_command(1, 1'b1);
        chk(st(1), 16'h1);
        host.cmd(sdram_ctl_pkg::CMD_PRE, 2'h0, 1'b0, 1'b1);
        host.no_operation_command(1, 1'b1);
        chk(st(0), 16'h4);
        host.no_operation_command(sdram_ctl_pkg::RP_CYC, 1'b1);
        chk(st(0), 16'h0);
        host.cmd(sdram_ctl_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
        host.no_operation_command(sdram_ctl_pkg::RP_CYC + 2, 1'b1);
        // power-down entry, hold and exit, then a command at once
        host.cmd(sdram_ctl_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
        host.no_operation_command(3, 1'b0);
        chk(pwr, 16'h1);
        host.cmd(sdram_ctl_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_ACT, 2'h2, 1'b0, 1'b1);
        host.no_operation_command(1, 1'b1);
        chk(st(2), 16'h1);
        host.no_operation_command(sdram_ctl_pkg::RCD_CYC, 1'b1);
        host.cmd(sdram_ctl_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
        host.no_operation_command(sdram_ctl_pkg::RP_CYC + 2, 1'b1);
        // self refresh entry and exit
        host.cmd(sdram_ctl_pkg::CMD_REF, 2'h0, 1'b0, 1'b0);
        host.no_operation_command(3, 1'b0);
        chk(pwr, 16'h3);
        host.cmd(sdram_ctl_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
        host.no_operation_command(1, 1'b1);
        chk(pwr, 16'h2);
        host.no_operation_command(sdram_ctl_pkg::XSR_CYC + 1, 1'b1);
        chk(pwr, 16'h0);
        // refresh and mode load from all-idle
        for (int k = 0; k < 2; k++) begin
            host.cmd(k ? sdram_ctl_pkg::CMD_MRS : sdram_ctl_pkg::CMD_REF,
                     2'h0, 1'b0, 1'b1);
            host.no_operation_command(1, 1'b1);
            chk(pwr, k ? 16'h5 : 16'h7);
            host.no_operation_command(sdram_ctl_pkg::RC_CYC, 1'b1);
            chk({pwr, all_idle}, 16'h1);
        end
        final_report;
    end
    // the tests need about 200 cycles; this allows more than ten times that
    initial begin
        #40000;
        bad_count++;
        final_report;
    end
endmodule
